// ---- rtl/spgc_defines.vh ----
/*
 Constants for the serial parity generate and check block: register
 offsets, field positions, reset values and the character width.
 Assumes inclusion by bare name from the design files of this block.
*/
//
// Contract
// - With parity enabled in asynchronous mode a parity bit is added on transmit and checked on receive, otherwise neither.
// - After reset parity addition and checking are off because the enable bit resets to 0.
// - In clocked synchronous mode no parity is generated or checked whatever the enable bit holds.
// - The odd-select bit picks even parity at 0, its reset value, and odd parity at 1.
// - The odd-select bit is ignored in synchronous mode and while parity is disabled.
// - Even parity makes data ones plus the parity bit an even count on transmit and checks it on receive.
// - Odd parity makes data ones plus the parity bit an odd count on transmit and checks it on receive.
`ifndef SPGC_DEFINES_VH
`define SPGC_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPGC_ADDR_W        4
`define SPGC_OFS_MODE      4'h0
`define SPGC_OFS_STATUS    4'h1
`define SPGC_OFS_COUNT     4'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPGC_BIT_SYNC      0
`define SPGC_BIT_ODD       4
`define SPGC_BIT_ENABLE    5
`define SPGC_BIT_PERR      0
`define SPGC_BIT_ACTIVE    1

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define SPGC_MODE_RST      8'h00
`define SPGC_COUNT_RST     8'h00
`define SPGC_DATA_W        8

`endif

// ---- rtl/spgc_parity_unit.v ----
/*
 Parity generator and checker for one character, with a registered result.
 Assumes data and controls come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "spgc_defines.vh"

module spgc_parity_unit
(
   // Clock and reset
   input  wire                    sys_clk,
   input  wire                    resetn,
   input  wire                    clk_en,
   // Controls
   input  wire                    active,
   input  wire                    odd_sel,
   // Transmit side
   input  wire                    tx_valid,
   input  wire [`SPGC_DATA_W-1:0] tx_data,
   output reg                     tx_par_ff,
   output reg                     tx_par_vld_ff,
   // Receive side
   input  wire                    rx_valid,
   input  wire [`SPGC_DATA_W-1:0] rx_data,
   input  wire                    rx_par,
   output reg                     rx_err_ff
);

   // ----------------------------------------------------------------------
   // Parity of the data ones, flipped for odd parity.
   // ----------------------------------------------------------------------
   function calc_par;
      input [`SPGC_DATA_W-1:0] d;
      input                    odd;
      begin
         calc_par = (^d) ^ odd;
      end
   endfunction

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_par_ff     <= 1'b0;
         tx_par_vld_ff <= 1'b0;
         rx_err_ff     <= 1'b0;
      end
      else if (clk_en)
      begin
         tx_par_ff     <= active & tx_valid & calc_par(tx_data, odd_sel);
         tx_par_vld_ff <= active & tx_valid;
         rx_err_ff     <= active & rx_valid & (calc_par(rx_data, odd_sel) != rx_par);
      end
   end

endmodule

// ---- rtl/spgc_top.v ----
/*
 Serial parity generate and check block with a small register port.
 Assumes the transmit and receive framers run on sys_clk and present
 one character per valid pulse; the register master is on sys_clk.
*/
`timescale 1ns/1ns
`include "spgc_defines.vh"

module spgc_top
(
   // Clock, reset and enable
   input  wire                    sys_clk,
   input  wire                    resetn,
   input  wire                    clk_en,
   // Register port
   input  wire [`SPGC_ADDR_W-1:0] reg_addr,
   input  wire [7:0]              reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [7:0]              reg_rdata_ff,
   // Transmit framer
   input  wire                    tx_valid,
   input  wire [`SPGC_DATA_W-1:0] tx_data,
   output reg                     tx_par_bit_ff,
   output reg                     tx_par_add_ff,
   // Receive framer
   input  wire                    rx_valid,
   input  wire [`SPGC_DATA_W-1:0] rx_data,
   input  wire                    rx_par,
   output reg                     rx_par_err_ff,
   // Status
   output reg                     parity_err_ff
);

   // ----------------------------------------------------------------------
   // Control register and derived enables
   // ----------------------------------------------------------------------
   reg  [7:0] mode_ff;
   reg  [7:0] err_count_ff;
   wire       parity_enable     = mode_ff[`SPGC_BIT_ENABLE];
   wire       parity_odd_select = mode_ff[`SPGC_BIT_ODD];
   wire       sync_mode         = mode_ff[`SPGC_BIT_SYNC];
   wire       active            = parity_enable & ~sync_mode;
   wire       odd_eff           = active & parity_odd_select;
   wire       unit_par;
   wire       unit_vld;
   wire       unit_err;
   wire       clr_hit;

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         mode_ff <= `SPGC_MODE_RST;
      else if (clk_en && reg_wr && reg_addr == `SPGC_OFS_MODE)
         mode_ff <= reg_wdata;
   end

   // ----------------------------------------------------------------------
   // Parity unit
   // ----------------------------------------------------------------------
   spgc_parity_unit spgc_parity_unit_inst
   (
      .sys_clk       (sys_clk),
      .resetn        (resetn),
      .clk_en        (clk_en),
      .active        (active),
      .odd_sel       (odd_eff),
      .tx_valid      (tx_valid),
      .tx_data       (tx_data),
      .tx_par_ff     (unit_par),
      .tx_par_vld_ff (unit_vld),
      .rx_valid      (rx_valid),
      .rx_data       (rx_data),
      .rx_par        (rx_par),
      .rx_err_ff     (unit_err)
   );

   // ----------------------------------------------------------------------
   // Outputs and sticky error, set wins over clear
   // ----------------------------------------------------------------------
   assign clr_hit = reg_wr && reg_addr == `SPGC_OFS_STATUS && reg_wdata[`SPGC_BIT_PERR];

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_par_bit_ff <= 1'b0;
         tx_par_add_ff <= 1'b0;
         rx_par_err_ff <= 1'b0;
         parity_err_ff <= 1'b0;
         err_count_ff  <= `SPGC_COUNT_RST;
      end
      else if (clk_en)
      begin
         tx_par_bit_ff <= unit_par;
         tx_par_add_ff <= unit_vld;
         rx_par_err_ff <= unit_err;
         if (unit_err)
         begin
            parity_err_ff <= 1'b1;
            err_count_ff  <= err_count_ff + 8'h01;
         end
         else if (clr_hit)
            parity_err_ff <= 1'b0;
         if (reg_wr && reg_addr == `SPGC_OFS_COUNT)
            err_count_ff <= `SPGC_COUNT_RST;
      end
   end

   // ----------------------------------------------------------------------
   // Read port, data one cycle after the strobe
   // ----------------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata_ff <= 8'h00;
      else if (clk_en)
      begin
         reg_rdata_ff <= 8'h00;
         if (reg_rd)
         begin
            case (reg_addr)
               `SPGC_OFS_MODE:   reg_rdata_ff <= mode_ff;
               `SPGC_OFS_STATUS: reg_rdata_ff <= {6'h00, active, parity_err_ff};
               `SPGC_OFS_COUNT:  reg_rdata_ff <= err_count_ff;
               default:          reg_rdata_ff <= 8'h00;
            endcase
         end
      end
   end

endmodule

// ---- sim/spgc_props.sv ----
/* Port assertions for spgc_top.
   Assumes binding to every spgc_top instance on sys_clk. */
`timescale 1ns/1ns
module spgc_props
(
   // Watched ports
   input logic       sys_clk,
   input logic       resetn,
   input logic [3:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_rdata_ff,
   input logic       tx_valid,
   input logic       tx_par_bit_ff,
   input logic       tx_par_add_ff,
   input logic       rx_valid,
   input logic       rx_par_err_ff,
   input logic       parity_err_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_tx_add_cause: assert property (tx_par_add_ff |-> $past(tx_valid, 2))
      else $error("parity added without a character");
   a_tx_bit_idle: assert property (!tx_par_add_ff |-> !tx_par_bit_ff)
      else $error("parity bit without add");
   a_rx_err_cause: assert property (rx_par_err_ff |-> $past(rx_valid, 2))
      else $error("receive error without a character");
   a_err_sets_flag: assert property (rx_par_err_ff |-> parity_err_ff)
      else $error("sticky flag not set");
   a_err_flag_holds: assert property (parity_err_ff &&
      !(reg_wr && reg_addr == 4'h1 && reg_wdata[0]) |=> parity_err_ff)
      else $error("sticky flag lost");
   a_err_flag_rise: assert property ($rose(parity_err_ff) |-> rx_par_err_ff)
      else $error("sticky flag rose alone");
   a_rd_data_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
      else $error("read data outside read");
   a_status_read: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1 |->
      reg_rdata_ff[7:2] == 6'h00 && reg_rdata_ff[0] == $past(parity_err_ff))
      else $error("status read wrong");
   c_tx_odd_bit: cover property (tx_par_add_ff && tx_par_bit_ff);
   c_rx_error: cover property (rx_par_err_ff);
   c_flag_clear: cover property ($fell(parity_err_ff));
endmodule
bind spgc_top spgc_props spgc_props_inst (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata_ff, .tx_valid, .tx_par_bit_ff, .tx_par_add_ff, .rx_valid, .rx_par_err_ff,
   .parity_err_ff);

// ---- sim/spgc_remote.sv ----
/* Remote transceiver model sending characters with a chosen parity.
   Assumes send is called right after a rising edge of sys_clk. */
`timescale 1ns/1ns
module spgc_remote
(
   // Receive framer side
   input  logic       sys_clk,
   output logic       rx_valid = 1'b0,
   output logic [7:0] rx_data = 8'h00,
   output logic       rx_par = 1'b0
);
   task automatic send(input logic [7:0] d, input logic odd, input logic bad);
      rx_valid <= 1'b1;
      rx_data  <= d;
      rx_par   <= ^d ^ odd ^ bad;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_data  <= ~d;
      rx_par   <= ~(^d ^ odd ^ bad);
   endtask
endmodule

// ---- sim/test_spgc_top.sv ----
/* Self-checking bench for spgc_top with the remote model.
   Assumes spgc_props and spgc_remote are compiled before it. */
`timescale 1ns/1ns
module test_spgc_top;
   logic       sys_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       tx_valid = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] reg_rdata_ff, rx_data, d, m;
   logic       tx_par_bit_ff, tx_par_add_ff, rx_valid, rx_par, rx_par_err_ff, parity_err_ff;
   logic       act, bad;
   logic [7:0] modes[6] = '{8'h00, 8'h20, 8'h30, 8'h21, 8'h31, 8'h10};
   int         fails = 0, cmp_count = 0, i, k, cnt;
   always #10 sys_clk = ~sys_clk;
   spgc_top spgc_top_inst (.sys_clk, .resetn, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata_ff, .tx_valid, .tx_data, .tx_par_bit_ff, .tx_par_add_ff, .rx_valid,
      .rx_data, .rx_par, .rx_par_err_ff, .parity_err_ff);
   spgc_remote spgc_remote_inst (.sys_clk, .rx_valid, .rx_data, .rx_par);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr    <= w;
      reg_rd    <= ~w;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      bus(1'b0, a, 8'h00);
      #1 chk(n, e, reg_rdata_ff);
   endtask
   task automatic finish_test();
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #200000 fails++;
      finish_test();
   end
   initial
   begin
      void'($urandom(2010));
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      bus(1'b1, 4'hf, 8'hff);
      rd(4'h0, 8'h00, "mode");
      rd(4'hf, 8'h00, "unmapped");
      for (k = 0; k < 7; k++)
      begin
         m   = (k < 6) ? modes[k] : 8'($urandom);
         act = m[5] & ~m[0];
         cnt = 0;
         bus(1'b1, 4'h0, m);
         rd(4'h0, m, "mode");
         for (i = 0; i < 12; i++)
         begin
            d   = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            bad = 1'($urandom);
            cnt = cnt + (act & bad);
            @(posedge sys_clk);
            tx_valid <= 1'b1;
            tx_data  <= d;
            spgc_remote_inst.send(d, m[4], bad);
            tx_valid <= 1'b0;
            @(posedge sys_clk);
            #1 chk("tx_add", act, tx_par_add_ff);
            chk("tx_bit", act & (^d ^ m[4]), tx_par_bit_ff);
            chk("rx_err", act & bad, rx_par_err_ff);
         end
         rd(4'h1, {6'h00, act, cnt != 0}, "status");
         rd(4'h2, 8'(cnt), "count");
         bus(1'b1, 4'h1, 8'h01);
         bus(1'b1, 4'h2, 8'h00);
         rd(4'h1, {6'h00, act, 1'b0}, "status");
      end
      bus(1'b1, 4'h0, 8'h31);
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(4'h0, 8'h00, "mode");
      rd(4'h1, 8'h00, "status");
      finish_test();
   end
endmodule
